//--- pdma_channel.sv
// peripheral dma channel pair: pointers, counters, enables and end flags
//
// Operation
// RULE_01: zero rx count halts, nonzero moves data
// RULE_02: zero tx count halts, nonzero moves data
// RULE_03: software loads tx pointer, count first
// RULE_04: software sets rx count to buffer size
// RULE_05: half duplex shares current pointer register
// RULE_06: half duplex shares current counter
// RULE_07: rx next pointer, shared in half duplex
// RULE_08: tx next counter, shared in half duplex
// RULE_09: rx enable sets unless disable also written
// RULE_10: rx disable turns off rx requests
// RULE_11: half duplex rx enable drops tx
// RULE_12: half duplex rx disable drops tx
// RULE_13: tx enable sets, half duplex needs no rx enable
// RULE_14: software never sets both enables half duplex
// RULE_15: tx disable turns off tx requests
// RULE_16: half duplex tx disable drops rx
// RULE_17: status bit 0 shows rx enable
// RULE_18: status bit 8 shows tx enable
// RULE_19: count zero reloads from next or stops
// RULE_20: pointer advances one, two or four bytes
// RULE_21: end and buffer flags from counter states
// RULE_22: nonzero counter write clears end flags
// RULE_23: reserved bits ignored and read zero
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module pdma_channel
  import pdma_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral ready strobes (same clock)
  input  wire logic        rx_ready,
  input  wire logic        tx_ready,
  // memory side of one item move
  output logic             rx_move,
  output logic             tx_move,
  output logic      [31:0] mem_addr,
  // flags back to the peripheral
  output logic             rx_end_flag,
  output logic             rx_buffer_full_flag,
  output logic             tx_end_flag,
  output logic             tx_buffer_empty_flag
);

  // reset synchroniser
  logic rst_meta, rst_sync;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire logic rst_n = rst_sync;

  // state registers: index 0 receive, 1 transmit
  logic [31:0]   cur_ptr  [2];
  logic [CW-1:0] cur_cnt  [2];
  logic [31:0]   nxt_ptr  [2];
  logic [CW-1:0] nxt_cnt  [2];
  logic [1:0]    req_en;
  logic [1:0]    end_f, buf_f;
  logic          half_duplex;
  logic [1:0]    size_sel;
  logic [1:0]    move_q;
  logic [31:0]   addr_q;
  logic [31:0]   rdata_q;
  logic          ready_q;

  logic [31:0]   next_cur_ptr [2];
  logic [CW-1:0] next_cur_cnt [2];
  logic [31:0]   next_nxt_ptr [2];
  logic [CW-1:0] next_nxt_cnt [2];
  logic [1:0]    next_req_en, next_end_f, next_buf_f, next_move;
  logic          next_half;
  logic [1:0]    next_size;
  logic [31:0]   next_addr, next_rdata;

  // apb: pready comes from a flop, so each access has one wait state; a write
  // lands at the edge where pready is seen high, a read loads data one edge earlier
  wire logic next_ready = psel & penable & ~ready_q;
  wire logic wr_acc = psel & penable & pwrite & ready_q;
  wire logic rd_acc = psel & penable & ~pwrite & ~ready_q;
  wire logic [31:0] wd = pwdata;

  // half duplex folds both names onto slot 0
  wire logic tx_slot = ~half_duplex;

  // item step in bytes
  logic [31:0] step;
  always_comb begin
    case (xfer_size_e'(size_sel))
      SIZE_BYTE: step = 32'h0000_0001;
      SIZE_HALF: step = 32'h0000_0002;
      SIZE_WORD: step = 32'h0000_0004;
      default:   step = 32'h0000_0004;
    endcase
  end

  // next state of pointers, counters, enables, flags
  always_comb begin
    logic [1:0] rdy;
    logic       s;
    logic [1:0] wr_cur, wr_nxt;
    s            = 1'b0;
    next_cur_ptr = cur_ptr;
    next_cur_cnt = cur_cnt;
    next_nxt_ptr = nxt_ptr;
    next_nxt_cnt = nxt_cnt;
    next_req_en  = req_en;
    next_end_f   = end_f;
    next_buf_f   = buf_f;
    next_half    = half_duplex;
    next_size    = size_sel;
    next_move    = 2'b00;
    next_addr    = addr_q;
    wr_cur       = 2'b00;
    wr_nxt       = 2'b00;
    rdy          = {tx_ready, rx_ready};
    // one item per ready strobe; half duplex direction is the enabled one
    for (int c = 0; c < 2; c++) begin
      s = (c == 1) ? tx_slot : 1'b0;
      if (rdy[c] && req_en[c] && cur_cnt[s] != '0) begin // RULE_01 RULE_02
        next_move[c]    = 1'b1;
        next_addr       = cur_ptr[s];
        next_cur_ptr[s] = cur_ptr[s] + step; // RULE_20
        next_cur_cnt[s] = cur_cnt[s] - 1'b1;
        if (cur_cnt[s] == {{(CW-1){1'b0}}, 1'b1}) begin
          if (nxt_cnt[s] != '0) begin // RULE_19
            next_cur_ptr[s] = nxt_ptr[s];
            next_cur_cnt[s] = nxt_cnt[s];
            next_nxt_ptr[s] = RST_VALUE;
            next_nxt_cnt[s] = '0;
            next_end_f[c]   = 1'b1; // RULE_21
          end else begin
            next_end_f[c] = 1'b1; // RULE_21
            next_buf_f[c] = 1'b1; // RULE_21
          end
        end
      end
    end
    // register writes win over the datapath update on the same field
    if (wr_acc) begin
      case (paddr)
        OFS_RX_PTR:  next_cur_ptr[0] = wd; // RULE_05
        OFS_TX_PTR:  next_cur_ptr[tx_slot] = wd; // RULE_05
        OFS_RX_NPTR: next_nxt_ptr[0] = wd; // RULE_07
        OFS_TX_NPTR: next_nxt_ptr[tx_slot] = wd; // RULE_07
        OFS_RX_CNT: begin
          next_cur_cnt[0] = wd[CW-1:0]; // RULE_06 RULE_23
          wr_cur[0] = 1'b1;
        end
        OFS_TX_CNT: begin
          next_cur_cnt[tx_slot] = wd[CW-1:0]; // RULE_06
          wr_cur[1] = 1'b1;
        end
        OFS_RX_NCNT: begin
          next_nxt_cnt[0] = wd[CW-1:0];
          wr_nxt[0] = 1'b1;
        end
        OFS_TX_NCNT: begin
          next_nxt_cnt[tx_slot] = wd[CW-1:0]; // RULE_08
          wr_nxt[1] = 1'b1;
        end
        OFS_CTRL: begin
          // reserved control bits simply not decoded
          if (wd[BIT_RX_EN] && !wd[BIT_RX_DIS]) begin
            next_req_en[0] = 1'b1; // RULE_09
            if (half_duplex) next_req_en[1] = 1'b0; // RULE_11
          end
          if (wd[BIT_TX_EN] && !(half_duplex && wd[BIT_RX_EN])) begin
            next_req_en[1] = 1'b1; // RULE_13
          end
          if (wd[BIT_RX_DIS]) begin
            next_req_en[0] = 1'b0; // RULE_10
            if (half_duplex) next_req_en[1] = 1'b0; // RULE_12
          end
          if (wd[BIT_TX_DIS]) begin
            next_req_en[1] = 1'b0; // RULE_15
            if (half_duplex) next_req_en[0] = 1'b0; // RULE_16
          end
        end
        OFS_CFG: begin
          next_half = wd[BIT_HALF];
          next_size = wd[BIT_SIZE_LO +: 2];
        end
        default: ;
      endcase
      // in half duplex a counter write speaks for both directions
      if (half_duplex) begin
        wr_cur = {2{|wr_cur}};
        wr_nxt = {2{|wr_nxt}};
      end
      // a nonzero counter write clears the flags; a completion
      // in the same cycle is not set then, software rearmed it
      for (int c = 0; c < 2; c++) begin
        if ((wr_cur[c] || wr_nxt[c]) && wd[CW-1:0] != '0) begin
          next_end_f[c] = 1'b0; // RULE_22
          next_buf_f[c] = 1'b0; // RULE_22
        end
      end
    end
  end

  // read mux; unused upper bits read zero
  always_comb begin
    next_rdata = RST_VALUE;
    if (rd_acc) begin
      case (paddr)
        OFS_RX_PTR:  next_rdata = cur_ptr[0];
        OFS_TX_PTR:  next_rdata = cur_ptr[tx_slot];
        OFS_RX_NPTR: next_rdata = nxt_ptr[0];
        OFS_TX_NPTR: next_rdata = nxt_ptr[tx_slot];
        OFS_RX_CNT:  next_rdata = 32'(cur_cnt[0]); // RULE_23
        OFS_TX_CNT:  next_rdata = 32'(cur_cnt[tx_slot]);
        OFS_RX_NCNT: next_rdata = 32'(nxt_cnt[0]);
        OFS_TX_NCNT: next_rdata = 32'(nxt_cnt[tx_slot]);
        OFS_STAT: begin
          next_rdata[BIT_STAT_RX] = req_en[0]; // RULE_17
          next_rdata[BIT_STAT_TX] = req_en[1]; // RULE_18
        end
        OFS_CFG: begin
          next_rdata[BIT_HALF] = half_duplex;
          next_rdata[BIT_SIZE_LO +: 2] = size_sel;
        end
        OFS_FLAGS: begin
          next_rdata[BIT_RX_END]   = end_f[0];
          next_rdata[BIT_RX_FULL]  = buf_f[0];
          next_rdata[BIT_TX_END]   = end_f[1];
          next_rdata[BIT_TX_EMPTY] = buf_f[1];
        end
        default: next_rdata = RST_VALUE; // write-only control reads zero
      endcase
    end
  end

  // register everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        cur_ptr[c] <= RST_VALUE;
        cur_cnt[c] <= '0;
        nxt_ptr[c] <= RST_VALUE;
        nxt_cnt[c] <= '0;
      end
      req_en      <= 2'b00;
      end_f       <= 2'b00;
      buf_f       <= 2'b00;
      half_duplex <= 1'b0;
      size_sel    <= SIZE_BYTE;
      move_q      <= 2'b00;
      addr_q      <= RST_VALUE;
      rdata_q     <= RST_VALUE;
      ready_q     <= 1'b0;
    end else begin
      cur_ptr     <= next_cur_ptr;
      cur_cnt     <= next_cur_cnt;
      nxt_ptr     <= next_nxt_ptr;
      nxt_cnt     <= next_nxt_cnt;
      req_en      <= next_req_en;
      end_f       <= next_end_f;
      buf_f       <= next_buf_f;
      half_duplex <= next_half;
      size_sel    <= next_size;
      move_q      <= next_move;
      addr_q      <= next_addr;
      rdata_q     <= next_rdata;
      ready_q     <= next_ready;
    end
  end

  // outputs straight from flops; the error response is never used, every
  // address answers and unmapped ones simply read zero
  assign prdata               = rdata_q;
  assign pready               = ready_q;
  assign pslverr              = 1'b0;
  assign rx_move              = move_q[0];
  assign tx_move              = move_q[1];
  assign mem_addr             = addr_q;
  assign rx_end_flag          = end_f[0];
  assign rx_buffer_full_flag  = buf_f[0];
  assign tx_end_flag          = end_f[1];
  assign tx_buffer_empty_flag = buf_f[1];

  // assertions
  a_stat_rx_bit: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    rd_acc && paddr == OFS_STAT |=> rdata_q[BIT_STAT_RX] == $past(req_en[0]))
    else $error("status rx bit wrong");
  a_stat_tx_bit: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    rd_acc && paddr == OFS_STAT |=> rdata_q[BIT_STAT_TX] == $past(req_en[1]))
    else $error("status tx bit wrong");
  a_stat_reserved: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
    rd_acc && paddr == OFS_STAT |=> rdata_q[31:BIT_STAT_TX+1] == '0 && rdata_q[BIT_STAT_TX-1:BIT_STAT_RX+1] == '0)
    else $error("status reserved bits set");
  a_cnt_reserved: assert property (@(posedge clk) disable iff (!rst_n) // RULE_23
    rd_acc && paddr == OFS_RX_CNT |=> rdata_q[31:CW] == '0)
    else $error("counter reserved bits set");
  a_rx_dis_wins: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    wr_acc && paddr == OFS_CTRL && wd[BIT_RX_DIS] |=> !req_en[0])
    else $error("rx disable ignored");
  a_rx_en_sets: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    wr_acc && paddr == OFS_CTRL && wd[BIT_RX_EN] && !wd[BIT_RX_DIS] && !wd[BIT_TX_DIS] |=> req_en[0])
    else $error("rx enable ignored");
  a_tx_en_sets: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    wr_acc && paddr == OFS_CTRL && wd[BIT_TX_EN] && !wd[BIT_TX_DIS]
      && !(half_duplex && (wd[BIT_RX_EN] || wd[BIT_RX_DIS])) |=> req_en[1])
    else $error("tx enable ignored");
  a_tx_dis_clr: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    wr_acc && paddr == OFS_CTRL && wd[BIT_TX_DIS] |=> !req_en[1])
    else $error("tx disable ignored");
  // half duplex: an rx enable must leave only the receive direction on
  a_half_excl: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    wr_acc && paddr == OFS_CTRL && half_duplex && wd[BIT_RX_EN] && !wd[BIT_RX_DIS] && !wd[BIT_TX_DIS]
      |=> req_en[0] && !req_en[1])
    else $error("half duplex rx enable left tx on");
  a_half_rx_dis: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    wr_acc && paddr == OFS_CTRL && half_duplex && wd[BIT_RX_DIS] |=> !req_en[1])
    else $error("half duplex rx disable left tx on");
  a_half_tx_dis: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    wr_acc && paddr == OFS_CTRL && half_duplex && wd[BIT_TX_DIS] |=> !req_en[0])
    else $error("half duplex tx disable left rx on");
  a_zero_halts: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    cur_cnt[0] == '0 |=> !rx_move)
    else $error("rx moved with zero count");
  a_tx_zero_halt: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    cur_cnt[tx_slot] == '0 |=> !tx_move)
    else $error("tx moved with zero count");
  a_rx_moves: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    rx_ready && req_en[0] && cur_cnt[0] != '0 |=> rx_move)
    else $error("rx strobe moved nothing");
  a_tx_moves: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    tx_ready && req_en[1] && cur_cnt[tx_slot] != '0 |=> tx_move)
    else $error("tx strobe moved nothing");
  a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
    next_move[0] && !wr_acc && cur_cnt[0] > 1 |=> cur_ptr[0] == $past(cur_ptr[0]) + $past(step))
    else $error("pointer step wrong");
  a_end_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_22
    wr_acc && paddr == OFS_RX_CNT && wd[CW-1:0] != '0 |=> !rx_end_flag)
    else $error("end flag not cleared");

  // last item of a buffer, with no register write that could rearm the flags
  sequence last_rx_item;
    !half_duplex && !wr_acc && rx_ready && req_en[0] && cur_cnt[0] == {{(CW-1){1'b0}}, 1'b1};
  endsequence
  sequence rx_reload_ready;
    last_rx_item ##0 nxt_cnt[0] != '0;
  endsequence
  sequence last_tx_item;
    !wr_acc && tx_ready && req_en[1] && cur_cnt[tx_slot] == {{(CW-1){1'b0}}, 1'b1};
  endsequence
  a_rx_end_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    last_rx_item |=> rx_end_flag)
    else $error("rx end flag not set");
  a_rx_full_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    last_rx_item ##0 nxt_cnt[0] == '0 |=> rx_buffer_full_flag)
    else $error("rx buffer full flag not set");
  a_rx_reload: assert property (@(posedge clk) disable iff (!rst_n) // RULE_19
    rx_reload_ready |=> cur_cnt[0] == $past(nxt_cnt[0]) && cur_ptr[0] == $past(nxt_ptr[0]) && nxt_cnt[0] == '0)
    else $error("next pair not loaded");
  a_tx_end_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    last_tx_item |=> tx_end_flag)
    else $error("tx end flag not set");
  a_tx_empty_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    last_tx_item ##0 nxt_cnt[tx_slot] == '0 |=> tx_buffer_empty_flag)
    else $error("tx buffer empty flag not set");

endmodule : pdma_channel

//--- pdma_channel_tb.sv
// self-checking testbench for the peripheral dma channel control block
module pdma_channel_tb import pdma_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        rx_on = 1'b0;
  logic        tx_on = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] prdata, rd, mem_addr;
  logic        pready, pslverr, rx_ready, tx_ready, rx_move, tx_move;
  logic        rx_end_flag, rx_buffer_full_flag, tx_end_flag, tx_buffer_empty_flag;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [31:0] seen_q[$];

  pdma_channel pdma_channel_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .rx_move(rx_move), .tx_move(tx_move), .mem_addr(mem_addr), .rx_end_flag(rx_end_flag),
    .rx_buffer_full_flag(rx_buffer_full_flag), .tx_end_flag(tx_end_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag));

  pdma_periph_model pdma_periph_model_i (.clk(clk), .arst_n(arst_n), .rx_on(rx_on), .tx_on(tx_on), .slow(slow),
    .rx_ready(rx_ready), .tx_ready(tx_ready));

  // 100 ns period
  always #50 clk = ~clk;

  // record the address of every item moved
  always @(posedge clk) begin
    if (rx_move === 1'b1 || tx_move === 1'b1) seen_q.push_back(mem_addr);
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    chk("slave error", 32'(pslverr), 32'h0);
    if (pready !== 1'b1) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask : rdc

  task ctl(input logic [31:0] c, input logic [31:0] s);
    acc(1'b1, OFS_CTRL, c, rd);
    rdc("status", OFS_STAT, s);
  endtask : ctl

  // program one buffer pair, let the peripheral strobe, then check addresses and flags
  task run(input logic tx, input xfer_size_e sz, input logic [15:0] c, input logic [15:0] nc,
           input logic [31:0] p, input logic [31:0] np);
    int step;
    int n;
    step = (sz == SIZE_BYTE) ? 1 : (sz == SIZE_HALF) ? 2 : 4;
    seen_q.delete();
    acc(1'b1, OFS_CFG, {29'h0, sz, 1'b0}, rd);
    acc(1'b1, tx ? OFS_TX_PTR : OFS_RX_PTR, p, rd);
    acc(1'b1, tx ? OFS_TX_CNT : OFS_RX_CNT, {16'h0, c}, rd);
    acc(1'b1, tx ? OFS_TX_NPTR : OFS_RX_NPTR, np, rd);
    acc(1'b1, tx ? OFS_TX_NCNT : OFS_RX_NCNT, {16'h0, nc}, rd);
    acc(1'b1, OFS_CTRL, tx ? 32'h0000_0100 : 32'h0000_0001, rd);
    rx_on <= !tx;
    tx_on <= tx;
    slow <= tx;
    n = 0;
    while (seen_q.size() < c + nc && n < 300) begin
      @(posedge clk);
      n++;
    end
    // strobes go on past the last item; a zero count must move nothing more
    repeat (12) @(posedge clk);
    rx_on <= 1'b0;
    tx_on <= 1'b0;
    chk("moves", 32'(seen_q.size()), 32'(c + nc));
    for (int i = 0; i < seen_q.size(); i++) chk("addr", seen_q[i], i < c ? p + i * step : np + (i - c) * step);
    chk("end flag", tx ? tx_end_flag : rx_end_flag, 32'h1);
    chk("buffer flag", tx ? tx_buffer_empty_flag : rx_buffer_full_flag, 32'h1);
    rdc("flag register", OFS_FLAGS, tx ? 32'h0000_000c : 32'h0000_0003);
    rdc("count", tx ? OFS_TX_CNT : OFS_RX_CNT, 32'h0);
    rdc("next count", tx ? OFS_TX_NCNT : OFS_RX_NCNT, 32'h0);
    acc(1'b1, OFS_CTRL, tx ? 32'h0000_0200 : 32'h0000_0002, rd);
    acc(1'b1, tx ? OFS_TX_NCNT : OFS_RX_NCNT, 32'h1, rd);
    @(posedge clk);
    chk("end clear", tx ? tx_end_flag : rx_end_flag, 32'h0);
  endtask : run

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) rdc("reset value", 8'(i * 4), 32'h0);
    acc(1'b1, OFS_RX_CNT, 32'hffff_ffff, rd);
    rdc("count width", OFS_RX_CNT, 32'h0000_ffff);
    rdc("unmapped", 8'h40, 32'h0);
    ctl(32'h0000_0001, 32'h0000_0001);
    ctl(32'h0000_0100, 32'h0000_0101);
    ctl(32'h0000_0002, 32'h0000_0100);
    ctl(32'h0000_0003, 32'h0000_0100);
    ctl(32'h0000_0200, 32'h0000_0000);
    ctl(32'hffff_fcfc, 32'h0000_0000);
    rdc("control", OFS_CTRL, 32'h0);
    acc(1'b1, OFS_RX_CNT, 32'h0, rd);
    run(1'b0, SIZE_WORD, 16'h2, 16'h1, 32'h0000_1000, 32'h0000_2000);
    run(1'b1, SIZE_BYTE, 16'h2, 16'h0, 32'h0000_3000, 32'h0);
    run(1'b1, SIZE_HALF, 16'h1, 16'h1, 32'h0000_4000, 32'h0000_5000);
    // half duplex: both name sets share one slot
    acc(1'b1, OFS_CFG, 32'h1, rd);
    rdc("config", OFS_CFG, 32'h1);
    acc(1'b1, OFS_TX_PTR, 32'h55aa_0010, rd);
    rdc("shared pointer", OFS_RX_PTR, 32'h55aa_0010);
    acc(1'b1, OFS_TX_CNT, 32'h7, rd);
    rdc("shared count", OFS_RX_CNT, 32'h7);
    acc(1'b1, OFS_RX_NPTR, 32'h0000_8000, rd);
    rdc("shared next pointer", OFS_TX_NPTR, 32'h0000_8000);
    acc(1'b1, OFS_TX_NCNT, 32'h9, rd);
    rdc("shared next count", OFS_RX_NCNT, 32'h9);
    ctl(32'h0000_0100, 32'h0000_0100);
    ctl(32'h0000_0001, 32'h0000_0001);
    ctl(32'h0000_0200, 32'h0000_0000);
    ctl(32'h0000_0100, 32'h0000_0100);
    ctl(32'h0000_0002, 32'h0000_0000);
    wrap_up;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule : pdma_channel_tb

//--- pdma_periph_model.sv
// behavioural serial peripheral that raises ready strobes toward the dma channel
module pdma_periph_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // strobe gating and pace
  input  wire logic rx_on,
  input  wire logic tx_on,
  input  wire logic slow,
  // ready strobes
  output logic      rx_ready,
  output logic      tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] pace;

  // one strobe every other cycle, or every fourth when slow, so gaps between items vary
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pace     <= 2'h0;
      rx_ready <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      pace     <= pace + 2'h1;
      rx_ready <= rx_on & (slow ? (pace == 2'h0) : ~rx_ready);
      tx_ready <= tx_on & (slow ? (pace == 2'h0) : ~tx_ready);
    end
  end
endmodule : pdma_periph_model

//--- pdma_pkg.sv
// shared constants for the peripheral dma channel control block
package pdma_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RX_PTR      = 8'h00;
  localparam logic [7:0] OFS_RX_CNT      = 8'h04;
  localparam logic [7:0] OFS_TX_PTR      = 8'h08;
  localparam logic [7:0] OFS_TX_CNT      = 8'h0c;
  localparam logic [7:0] OFS_RX_NPTR     = 8'h10;
  localparam logic [7:0] OFS_RX_NCNT     = 8'h14;
  localparam logic [7:0] OFS_TX_NPTR     = 8'h18;
  localparam logic [7:0] OFS_TX_NCNT     = 8'h1c;
  localparam logic [7:0] OFS_CTRL        = 8'h20;
  localparam logic [7:0] OFS_STAT        = 8'h24;
  localparam logic [7:0] OFS_CFG         = 8'h28;
  localparam logic [7:0] OFS_FLAGS       = 8'h2c;
  // control and status bit positions
  localparam int         BIT_RX_EN       = 0;
  localparam int         BIT_RX_DIS      = 1;
  localparam int         BIT_TX_EN       = 8;
  localparam int         BIT_TX_DIS      = 9;
  localparam int         BIT_STAT_RX     = 0;
  localparam int         BIT_STAT_TX     = 8;
  // flag register bit positions
  localparam int         BIT_RX_END      = 0;
  localparam int         BIT_RX_FULL     = 1;
  localparam int         BIT_TX_END      = 2;
  localparam int         BIT_TX_EMPTY    = 3;
  // config register: bit 0 half duplex, bits 2:1 transfer size
  localparam int         BIT_HALF        = 0;
  localparam int         BIT_SIZE_LO     = 1;
  localparam int         CNT_W           = 16;
  localparam logic [31:0] RST_VALUE      = 32'h0000_0000;
  // transfer size encodings
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } xfer_size_e;
endpackage : pdma_pkg
